// [shared/rss_defines.vh]
// Summary of operation
// R1 - Rightmost status digit shows combined blocking inputs
// R2 - Blocking digit: 0 none,1 low,2 high,3 both
// R3 - Middle green digit shows angle-basis input
// R4 - External select: input 0 sine, 1 cosine
// R5 - Leftmost green digit shows remote reset input
// R6 - Test mode asserts start/operate outputs singly
// R7 - Serial address zero means communication unused
// R8 - Line rates 300..9600 baud, default 9600
// R9 - Comm counter zero when working, else scrolls
// R10 - Remote setting changes need stored password
// R11 - Key pair or command clears records 1-8
// R12 - Supply interruption clears recorded-value registers
// R13 - Address, rate, password survive supply loss
// R14 - Low-set operate delay 0.1-1.0s, 1.0-10.0s
// R15 - Saturating low/high start counters 0-255
// R16 - Synchronise blocking, angle and reset inputs
`ifndef RSS_DEFINES_VH
`define RSS_DEFINES_VH
// Register byte addresses
`define RSS_ADDR_STATUS 8'h00
`define RSS_ADDR_CTRL 8'h04
`define RSS_ADDR_TEST 8'h08
`define RSS_ADDR_COMM_ADDR 8'h0c
`define RSS_ADDR_RATE 8'h10
`define RSS_ADDR_PASSWORD 8'h14
`define RSS_ADDR_PW_ENTRY 8'h18
`define RSS_ADDR_COMM_CNT 8'h1c
`define RSS_ADDR_DELAY 8'h20
`define RSS_ADDR_IRQ_STAT 8'h24
`define RSS_ADDR_IRQ_MASK 8'h28
`define RSS_ADDR_REC_LOW 8'h2c
`define RSS_ADDR_REC_HIGH 8'h30
`define RSS_ADDR_CMD 8'h34
// Field positions
`define RSS_CTRL_EXT_SEL 0
`define RSS_CTRL_RANGE 1
`define RSS_CMD_CLEAR 0
// Line rate codes
`define RSS_RATE_300 3'h0
`define RSS_RATE_1200 3'h1
`define RSS_RATE_2400 3'h2
`define RSS_RATE_4800 3'h3
`define RSS_RATE_9600 3'h4
// Reset values
`define RSS_RATE_RESET 3'h4
`define RSS_DELAY_RESET 7'h01
`define RSS_MASK_RESET 4'h0
// Interrupt status bits
`define RSS_IRQ_LOW_START 0
`define RSS_IRQ_HIGH_START 1
`define RSS_IRQ_CLEARED 2
`define RSS_IRQ_PW_REFUSED 3
// Timing: delay step 100 ms at 250 MHz
`define RSS_CLK_MHZ 250
`define RSS_STEP_MS 100
`define RSS_STEP_CYCLES (`RSS_STEP_MS * 1000 * `RSS_CLK_MHZ)
// Comm counter scroll period 10 ms
`define RSS_SCROLL_MS 10
`define RSS_SCROLL_CYCLES (`RSS_SCROLL_MS * 1000 * `RSS_CLK_MHZ)
`endif

// [rtl/rss_sync.v]
`timescale 1ns/1ps
// Two-flop synchroniser for a bundle of level inputs
module rss_sync #(
    parameter WIDTH = 3
) (
    input wire clk,
    input wire rst_b,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_q; // First stage, read only by second
    reg [WIDTH-1:0] sync_q; // Second stage, safe to use

    // Sample twice to settle metastability
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= async_in; // R16
            sync_q <= meta_q; // R16
        end
    end

    assign sync_out = sync_q;
endmodule // rss_sync

// [rtl/rss_top.v]
`timescale 1ns/1ps
`include "rss_defines.vh"
// Status and setup registers of the neutral overcurrent module
// Setup values sit in flops that only rst_b clears. supply_lost
// stands for a dip of the auxiliary supply: it wipes the records
// but leaves address, line rate and password in place.
// Field inputs pass a two-flop synchroniser, so the display and
// the gating lag the pins by two clocks; clean levels are worth it.
module rss_top #(
    parameter STEP_CYCLES = `RSS_STEP_CYCLES,
    parameter SCROLL_CYCLES = `RSS_SCROLL_CYCLES
) (
    input wire clk,
    input wire rst_b,

    // Register bus, read data one cycle after rd
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata,

    // Field inputs, levels from the terminal
    input wire low_stage_block_input,
    input wire high_stage_block_input,
    input wire angle_basis_select_input,
    input wire remote_reset_input,

    // Front keys and record clear sources
    input wire step_key,
    input wire reset_key,
    input wire clear_records_command,
    input wire supply_lost,

    // Serial link state and origin of a write
    input wire comm_ok,
    input wire remote_write,

    // One-cycle start pulses for the counters
    input wire low_stage_start,
    input wire high_stage_start,

    // Protection levels, passed through or forced in test
    input wire low_stage_start_in,
    input wire low_stage_operate_in,
    input wire high_stage_start_in,
    input wire high_stage_operate_in,

    // Output relay drives
    output wire low_start_out,
    output wire low_operate_out,
    output wire high_start_out,
    output wire high_operate_out,

    // Derived settings and status
    output wire use_cosine,
    output wire comm_enabled,
    output wire [2:0] line_rate,
    output reg low_delay_done,
    output wire irq
);
    // Synchronised inputs: low block, high block, angle, remote reset
    wire [3:0] sync_w;
    rss_sync #(.WIDTH(4)) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .async_in({remote_reset_input, angle_basis_select_input,
                   high_stage_block_input, low_stage_block_input}),
        .sync_out(sync_w)
    );
    // Bit order follows the blocking digit: low-set stage is bit 0
    wire blk_low = sync_w[0];
    wire blk_high = sync_w[1];
    wire angle_sel = sync_w[2];
    wire rem_reset = sync_w[3];

    // Digit values; blocking digit is a two-bit code
    // Gaps between digits read zero so each nibble is one digit
    wire [1:0] block_digit = {blk_high, blk_low}; // R1 R2
    wire [31:0] status_word = {20'h0, 3'h0, rem_reset, 3'h0, angle_sel,
                               2'h0, block_digit}; // R3 R5

    // Setup state; held in the always-on domain, not by rst-from-supply; the start records clear on supply_lost
    reg [1:0] ctrl_q; // External select, delay range
    reg [2:0] test_q; // 0 off, 1..4 selects one output
    reg [7:0] comm_addr_q; // Serial address
    reg [2:0] rate_q; // Line rate code
    reg [15:0] password_q; // Stored password
    reg [15:0] pw_entry_q; // Password offered by remote party
    reg [7:0] comm_cnt_q; // Bus communication counter
    reg [6:0] delay_q; // Delay setting in steps
    reg [3:0] irq_stat_q; // Sticky events
    reg [3:0] irq_mask_q; // Interrupt enables
    reg [7:0] rec_low_q; // Low-set start count
    reg [7:0] rec_high_q; // High-set start count

    // Remote writes need the password; local writes always pass
    // The entry is kept, so a remote party stays trusted until the
    // stored password is changed; a refused write raises an event
    wire pw_ok = (pw_entry_q == password_q);
    wire wr_ok = wr && (!remote_write || pw_ok); // R10
    wire wr_refused = wr && remote_write && !pw_ok; // R10

    // Clear sources for the records
    // Both keys must be high in one cycle; one key alone clears nothing
    wire keys_clear = step_key && reset_key;
    wire cmd_clear = wr_ok && (addr == `RSS_ADDR_CMD) &&
                     wdata[`RSS_CMD_CLEAR];
    wire rec_clear = keys_clear || clear_records_command || cmd_clear ||
                     supply_lost; // R11 R12

    // Test codes: one relay at a time, so a wiring fault shows alone
    localparam TEST_OFF = 3'h0; // Normal pass-through
    localparam TEST_LOW_START = 3'h1; // Low-set start relay
    localparam TEST_LOW_OP = 3'h2; // Low-set operate relay
    localparam TEST_HIGH_START = 3'h3; // High-set start relay
    localparam TEST_HIGH_OP = 3'h4; // High-set operate relay

    // Test mode: one output forced at a time, else pass-through
    assign low_start_out = (test_q == TEST_LOW_START) ? 1'b1 :
        (test_q == TEST_OFF) ? low_stage_start_in : 1'b0; // R6
    assign low_operate_out = (test_q == TEST_LOW_OP) ? 1'b1 :
        (test_q == TEST_OFF) ? (low_stage_operate_in & ~blk_low) : 1'b0; // R6
    assign high_start_out = (test_q == TEST_HIGH_START) ? 1'b1 :
        (test_q == TEST_OFF) ? high_stage_start_in : 1'b0; // R6
    assign high_operate_out = (test_q == TEST_HIGH_OP) ? 1'b1 :
        (test_q == TEST_OFF) ?
        (high_stage_operate_in & ~blk_high) : 1'b0; // R6

    // Characteristic select follows the angle input only when enabled
    assign use_cosine = ctrl_q[`RSS_CTRL_EXT_SEL] & angle_sel; // R4
    assign comm_enabled = (comm_addr_q != 8'h00); // R7
    assign line_rate = rate_q; // R8

    // Setup registers; not cleared by supply loss, only by rst_b
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            // Power-on defaults: 9600 Bd, shortest delay, all masked
            ctrl_q <= 2'h0;
            test_q <= 3'h0;
            comm_addr_q <= 8'h00;
            rate_q <= `RSS_RATE_RESET; // R8
            password_q <= 16'h0000;
            pw_entry_q <= 16'h0000;
            delay_q <= `RSS_DELAY_RESET;
            irq_mask_q <= `RSS_MASK_RESET;
        end else if (wr) begin
            // Password entry itself is always accepted
            if (addr == `RSS_ADDR_PW_ENTRY) begin
                pw_entry_q <= wdata[15:0];
            end else if (wr_ok) begin
                if (addr == `RSS_ADDR_CTRL) begin
                    // Bit 0 lets the angle input pick the characteristic
                    ctrl_q <= wdata[1:0];
                end else if (addr == `RSS_ADDR_TEST) begin
                    // Codes above four turn the test off
                    test_q <= (wdata[2:0] > TEST_HIGH_OP) ? TEST_OFF :
                        wdata[2:0]; // R6
                end else if (addr == `RSS_ADDR_COMM_ADDR) begin
                    // Zero switches the serial side off
                    comm_addr_q <= wdata[7:0]; // R13
                end else if (addr == `RSS_ADDR_RATE) begin
                    // Codes beyond the rate table rejected, rate kept
                    if (wdata <= {29'h0, `RSS_RATE_9600}) begin
                        rate_q <= wdata[2:0]; // R8 R13
                    end
                end else if (addr == `RSS_ADDR_PASSWORD) begin
                    // Write only; never read back over the bus
                    password_q <= wdata[15:0]; // R13
                end else if (addr == `RSS_ADDR_DELAY) begin
                    // Range 0: 1..10 steps; range 1: 10..100 steps
                    if (wdata[6:0] >= 7'h01 && wdata[6:0] <= 7'h0a) begin
                        delay_q <= wdata[6:0]; // R14
                    end
                end else if (addr == `RSS_ADDR_IRQ_MASK) begin
                    // Enables for the single irq level
                    irq_mask_q <= wdata[3:0];
                end
            end
        end
    end

    // Comm counter: held at zero when link works, scrolls otherwise
    // Address zero means no link is expected, so it never scrolls;
    // the divider restarts whenever the link comes back
    reg [31:0] scroll_q; // Scroll rate divider
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scroll_q <= 32'h0;
            comm_cnt_q <= 8'h00;
        end else if (comm_ok || !comm_enabled) begin
            scroll_q <= 32'h0;
            comm_cnt_q <= 8'h00; // R9
        end else if (scroll_q >= SCROLL_CYCLES - 1) begin
            scroll_q <= 32'h0;
            comm_cnt_q <= comm_cnt_q + 8'h01; // R9 wraps 255 to 0
        end else begin
            scroll_q <= scroll_q + 32'h1;
        end
    end

    // Start counters saturate at 255, cleared by any clear source
    // Clear beats a start pulse in the same cycle, so a wipe is total;
    // saturation stops a long fault from wrapping to a small count
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rec_low_q <= 8'h00;
            rec_high_q <= 8'h00;
        end else if (rec_clear) begin
            rec_low_q <= 8'h00; // R11 R12
            rec_high_q <= 8'h00;
        end else begin
            if (low_stage_start && rec_low_q != 8'hff) begin
                rec_low_q <= rec_low_q + 8'h01; // R15
            end
            if (high_stage_start && rec_high_q != 8'hff) begin
                rec_high_q <= rec_high_q + 8'h01; // R15
            end
        end
    end

    // Low-set operate delay: step enable then step count
    // Range bit multiplies the setting by ten: 0.1 s or 1 s steps.
    // The divider runs only while the stage is started, and done is
    // registered, so it rises one clock after the last step
    reg [31:0] step_div_q; // 100 ms divider
    reg [6:0] steps_q; // Elapsed steps while started
    wire step_en = (step_div_q >= STEP_CYCLES - 1);
    wire [6:0] delay_steps = ctrl_q[`RSS_CTRL_RANGE] ?
        (delay_q * 7'd10) : delay_q; // R14
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            step_div_q <= 32'h0;
            steps_q <= 7'h00;
            low_delay_done <= 1'b0;
        end else if (!low_stage_start_in || blk_low) begin
            // Start dropped or stage blocked: restart timing
            step_div_q <= 32'h0;
            steps_q <= 7'h00;
            low_delay_done <= 1'b0;
        end else begin
            step_div_q <= step_en ? 32'h0 : step_div_q + 32'h1;
            if (step_en && steps_q < delay_steps) begin
                steps_q <= steps_q + 7'h01;
            end
            low_delay_done <= (steps_q >= delay_steps); // R14
        end
    end

    // Sticky events, set wins over write-one-to-clear
    // A refused remote write is an event too, so software learns
    // of a wrong password; the mask gates only the irq output
    wire [3:0] irq_set = {wr_refused, rec_clear, high_stage_start,
                          low_stage_start};
    wire [3:0] irq_clr = (wr_ok && addr == `RSS_ADDR_IRQ_STAT) ?
                         wdata[3:0] : 4'h0;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_stat_q <= 4'h0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
        end
    end
    assign irq = |(irq_stat_q & irq_mask_q);

    // Read data registered, valid the cycle after rd
    // Write-only words read zero, so the password never leaks
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= 32'h0;
        end else if (rd) begin
            if (addr == `RSS_ADDR_STATUS) begin
                // Display digits, one per nibble
                rdata <= status_word; // R1 R3 R5
            end else if (addr == `RSS_ADDR_CTRL) begin
                rdata <= {30'h0, ctrl_q};
            end else if (addr == `RSS_ADDR_TEST) begin
                rdata <= {29'h0, test_q};
            end else if (addr == `RSS_ADDR_COMM_ADDR) begin
                rdata <= {24'h0, comm_addr_q};
            end else if (addr == `RSS_ADDR_RATE) begin
                rdata <= {29'h0, rate_q};
            end else if (addr == `RSS_ADDR_COMM_CNT) begin
                // Live count, scrolling while the link is down
                rdata <= {24'h0, comm_cnt_q};
            end else if (addr == `RSS_ADDR_DELAY) begin
                rdata <= {25'h0, delay_q};
            end else if (addr == `RSS_ADDR_IRQ_STAT) begin
                // Sticky events as they stand before this edge
                rdata <= {28'h0, irq_stat_q};
            end else if (addr == `RSS_ADDR_IRQ_MASK) begin
                rdata <= {28'h0, irq_mask_q};
            end else if (addr == `RSS_ADDR_REC_LOW) begin
                // Start counts, zeroed by any clear source
                rdata <= {24'h0, rec_low_q};
            end else if (addr == `RSS_ADDR_REC_HIGH) begin
                rdata <= {24'h0, rec_high_q};
            end else begin
                // Password, entry, command and unmapped read zero
                rdata <= 32'h0;
            end
        end
    end
endmodule // rss_top

// [sim/rss_assertions.sv]
`timescale 1ns/1ps
`include "rss_defines.vh"
// Port-level checks on the status and setup registers
module rss_assertions (
    input wire clk,
    input wire rst_b,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    input wire [31:0] rdata,
    input wire low_stage_block_input,
    input wire high_stage_block_input,
    input wire angle_basis_select_input,
    input wire supply_lost,
    input wire remote_write,
    input wire high_stage_start,
    input wire use_cosine,
    input wire comm_enabled,
    input wire [2:0] line_rate
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Local write of the rate register
    sequence s_rate_wr;
        wr && addr == `RSS_ADDR_RATE && !remote_write;
    endsequence
    // Supply held off, then a read of the high start count
    sequence s_lost;
        supply_lost ##1 (supply_lost && rd && !high_stage_start &&
            addr == `RSS_ADDR_REC_HIGH);
    endsequence
    a_status_read:
    assert property (rd && addr == `RSS_ADDR_STATUS |=> rdata[4:0] ==
        {$past(angle_basis_select_input, 3), 2'h0,
        $past(high_stage_block_input, 3), $past(low_stage_block_input, 3)})
        else $error("status digits wrong");
    a_cos_follows:
    assert property (use_cosine |-> $past(angle_basis_select_input, 2))
        else $error("cosine without angle input");
    a_rate_legal:
    assert property (line_rate <= 3'h4) else $error("rate code out of range");
    a_rate_taken:
    assert property (s_rate_wr ##0 wdata < 32'h5 |=>
        line_rate == $past(wdata[2:0])) else $error("rate not taken");
    a_rate_bad:
    assert property (wr && addr == `RSS_ADDR_RATE && wdata > 32'h4 |=>
        $stable(line_rate)) else $error("bad rate accepted");
    a_addr_zero:
    assert property (wr && addr == `RSS_ADDR_COMM_ADDR && !remote_write |=>
        comm_enabled == ($past(wdata[7:0]) != 8'h0))
        else $error("comm enable wrong");
    a_supply_clear:
    assert property (s_lost |=> rdata == 32'h0)
        else $error("records kept over supply loss");
    a_rate_kept:
    assert property (supply_lost && !wr |=> $stable(line_rate))
        else $error("rate lost on supply loss");
endmodule // rss_assertions

bind rss_top rss_assertions u_chk (.clk(clk), .rst_b(rst_b), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .low_stage_block_input(low_stage_block_input),
    .high_stage_block_input(high_stage_block_input),
    .angle_basis_select_input(angle_basis_select_input),
    .supply_lost(supply_lost), .remote_write(remote_write),
    .high_stage_start(high_stage_start), .use_cosine(use_cosine),
    .comm_enabled(comm_enabled), .line_rate(line_rate));

// [sim/rss_link_model.sv]
`timescale 1ns/1ps
// Serial link party: link state, clear command, remote write flag
module rss_link_model (
    input wire link_up,
    input wire send_clear,
    input wire remote_req,
    output wire comm_ok,
    output wire clear_records_command,
    output wire remote_write
);
    assign comm_ok = link_up;
    assign clear_records_command = send_clear;
    // Marks writes as remote, so the password gate applies
    assign remote_write = remote_req;
endmodule // rss_link_model

// [sim/relay_status_comm_setup_registers_tb.sv]
`timescale 1ns/1ps
`include "rss_defines.vh"
module relay_status_comm_setup_registers_tb;
    reg clk, rst_b, wr, rd, rd_q, lo_b, hi_b, ang, rem, stp, rsk, sup;
    reg link, clr, rreq, lo_s, hi_s, a_irq;
    reg [3:0] ins;
    reg [7:0] addr;
    reg [31:0] wdata, v;
    reg [31:0] expq[$];
    wire [31:0] rdata;
    wire [3:0] outs;
    wire [2:0] rate;
    wire use_cos, comm_en, irq, ok, cmd, rw, dly;
    integer mismatches, checked, cyc, seed, i;
    rss_top #(.STEP_CYCLES(4), .SCROLL_CYCLES(2)) dut (.clk(clk),
        .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .low_stage_block_input(lo_b),
        .high_stage_block_input(hi_b), .angle_basis_select_input(ang),
        .remote_reset_input(rem), .step_key(stp), .reset_key(rsk),
        .clear_records_command(cmd), .supply_lost(sup), .comm_ok(ok),
        .remote_write(rw), .low_stage_start(lo_s), .high_stage_start(hi_s),
        .low_stage_start_in(ins[3]), .low_stage_operate_in(ins[2]),
        .high_stage_start_in(ins[1]), .high_stage_operate_in(ins[0]),
        .low_start_out(outs[3]), .low_operate_out(outs[2]),
        .high_start_out(outs[1]), .high_operate_out(outs[0]),
        .use_cosine(use_cos), .comm_enabled(comm_en), .line_rate(rate),
        .low_delay_done(dly), .irq(irq));
    rss_link_model link_far (.link_up(link), .send_clear(clr),
        .remote_req(rreq), .comm_ok(ok), .clear_records_command(cmd),
        .remote_write(rw));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task tally_and_finish;
        begin
            if (mismatches == 0 && checked > 0) begin
                $display("[ PASS ]");
            end else begin
                $display("[ FAIL ]");
            end
            $finish;
        end
    endtask
    task check(input [31:0] seen, input [31:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("BAD %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // Bus strobes wait for an edge first, so no signal moves twice a step
    task wr_reg(input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
        end
    endtask
    task rd_reg(input [7:0] a, input [31:0] e);
        begin
            @(posedge clk);
            expq.push_back(e);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
        end
    endtask
    task pulses(input integer n);
        repeat (n) begin
            @(posedge clk);
            {lo_s, hi_s} <= 2'h3;
            @(posedge clk);
            {lo_s, hi_s} <= 2'h0;
        end
    endtask
    // Read data stands from the cycle after the strobe until the next read; timeout here too
    always @(posedge clk) begin
        if (rd_q) begin
            check(rdata, expq.pop_front());
        end
        rd_q <= rd;
        cyc = cyc + 1;
        if (cyc == 20000) begin
            mismatches = mismatches + 1;
            tally_and_finish;
        end
    end
    initial begin
        {rst_b, wr, rd, rd_q, lo_b, hi_b, ang, rem, stp, rsk, sup} = 11'h0;
        {link, clr, rreq, lo_s, hi_s, ins, addr, wdata} = 49'h0;
        mismatches = 0;
        checked = 0;
        cyc = 0;
        seed = 29694;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rd_reg(`RSS_ADDR_RATE, 32'h4);
        for (i = 0; i < 8; i = i + 1) begin
            v = $random(seed);
            @(posedge clk);
            {rem, ang, hi_b, lo_b} <= {v[1:0], i[1:0]};
            repeat (4) @(posedge clk);
            rd_reg(`RSS_ADDR_STATUS, {v[1], 3'h0, v[0], 2'h0, i[1:0]});
        end
        for (i = 0; i < 4; i = i + 1) begin
            wr_reg(`RSS_ADDR_CTRL, i[0]);
            ang <= i[1];
            repeat (4) @(posedge clk);
            #1 check(use_cos, i[0] & i[1]);
        end
        for (i = 0; i < 5; i = i + 1) begin
            wr_reg(`RSS_ADDR_RATE, i);
            #1 check(rate, i);
            rd_reg(`RSS_ADDR_RATE, i);
        end
        wr_reg(`RSS_ADDR_RATE, 32'h5);
        rd_reg(`RSS_ADDR_RATE, 32'h4);
        wr_reg(`RSS_ADDR_COMM_ADDR, 32'h0);
        #1 check(comm_en, 1'b0);
        wr_reg(`RSS_ADDR_COMM_ADDR, 32'h21);
        #1 check(comm_en, 1'b1);
        repeat (20) @(posedge clk);
        // Link down: one step per two cycles since the address write
        rd_reg(`RSS_ADDR_COMM_CNT, 32'ha);
        link <= 1'b1;
        repeat (4) @(posedge clk);
        rd_reg(`RSS_ADDR_COMM_CNT, 32'h0);
        {lo_b, hi_b} <= 2'h0;
        for (i = 1; i < 5; i = i + 1) begin
            wr_reg(`RSS_ADDR_TEST, i);
            #1 check(outs, 4'h8 >> (i - 1));
        end
        v = $random(seed);
        wr_reg(`RSS_ADDR_TEST, 32'h0);
        ins <= v[3:0];
        @(posedge clk);
        #1 check(outs, v[3:0]);
        // Operate delay: 3 steps of 4 cycles, then the x10 range
        for (i = 0; i < 2; i = i + 1) begin
            @(posedge clk);
            ins <= 4'h0;
            wr_reg(`RSS_ADDR_DELAY, 32'h3);
            wr_reg(`RSS_ADDR_CTRL, i << 1);
            ins <= 4'h8;
            repeat (12 + 108 * i) @(posedge clk);
            #1 check(dly, 1'b0);
            @(posedge clk);
            #1 check(dly, 1'b1);
        end
        // Key pair, serial command, then supply loss
        for (i = 0; i < 3; i = i + 1) begin
            pulses(3);
            rd_reg(`RSS_ADDR_REC_LOW, 32'h3);
            {sup, clr, stp, rsk} <= (i == 0) ? 4'h3 : (i == 1) ? 4'h4 : 4'h8;
            @(posedge clk);
            // Supply loss stays up across the read that follows
            {clr, stp, rsk} <= 3'h0;
            rd_reg(`RSS_ADDR_REC_HIGH, 32'h0);
            sup <= 1'b0;
        end
        rd_reg(`RSS_ADDR_COMM_ADDR, 32'h21);
        rd_reg(`RSS_ADDR_IRQ_STAT, 32'h7);
        wr_reg(`RSS_ADDR_IRQ_MASK, 32'h0);
        #1 a_irq = irq;
        wr_reg(`RSS_ADDR_IRQ_MASK, 32'hf);
        #1 check(irq ^ a_irq, 1'b1);
        wr_reg(`RSS_ADDR_IRQ_STAT, 32'h7);
        #1 check(irq, 1'b0);
        rd_reg(`RSS_ADDR_IRQ_STAT, 32'h0);
        pulses(260);
        rd_reg(`RSS_ADDR_REC_LOW, 32'hff);
        wr_reg(`RSS_ADDR_PASSWORD, 32'h5a);
        rreq <= 1'b1;
        wr_reg(`RSS_ADDR_RATE, 32'h1);
        rd_reg(`RSS_ADDR_RATE, 32'h4);
        wr_reg(`RSS_ADDR_PW_ENTRY, 32'h5a);
        wr_reg(`RSS_ADDR_RATE, 32'h1);
        rd_reg(`RSS_ADDR_RATE, 32'h1);
        rreq <= 1'b0;
        // Start events from the long pulse run are still pending
        rd_reg(`RSS_ADDR_IRQ_STAT, 32'hb);
        rd_reg(8'h3c, 32'h0);
        repeat (3) @(posedge clk);
        tally_and_finish;
    end
endmodule // relay_status_comm_setup_registers_tb
